// ### rtl/frc_ctrl.sv
`timescale 1ns/1ps
`include "frc_consts.svh"
// How it works
// - in the ram-executed mode a maskable interrupt is acknowledged at once while a command runs.
// - a watchdog, oscillation-stop or voltage-monitor interrupt aborts the command and resets the flash, then after a fixed delay is acknowledged.
// - the watchdog keeps running during a command; its tick is passed on through one register, one clock later.
// - rom-executed mode with erase suspend enabled suspends erase after the suspend delay, and clearing the erase request resumes it.
// - rom-executed mode with erase suspend disabled holds the maskable acknowledge until erase ends.
// - rom-executed mode with program suspend enabled suspends program after the suspend delay, and clearing the program request resumes it.
// - rom-executed mode with program suspend disabled holds the maskable acknowledge until program ends.
// - a protected bit is set only by a write of 0 then 1 with no interrupt between.
module frc_ctrl #(
  parameter int SUSPEND_CYC = `FRC_SUSPEND_DELAY_CYC,
  parameter int ABORT_CYC = `FRC_ABORT_DELAY_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  // command from cpu
  input wire logic cmd_start,
  input wire logic [1:0] cmd_code,
  input wire logic erase_suspend_enable,
  input wire logic program_suspend_enable,
  input wire logic erase_suspend_request,
  input wire logic program_suspend_request,
  // protected bit writes
  input wire logic pbit_wr,
  input wire logic [1:0] pbit_sel,
  input wire logic pbit_wdata,
  // interrupts
  input wire logic maskable_irq,
  input wire logic fatal_irq,
  input wire logic wdt_tick_in,
  // flash array side
  input wire logic flash_done,
  // outputs
  output logic irq_ack,
  output logic fatal_ack,
  output logic wdt_tick_out,
  output logic flash_run,
  output logic flash_reset,
  output logic rewrite_enable_bit,
  output logic lock_disable_bit,
  output logic rom_rewrite_select_bit,
  output frc_pkg::frc_status_s status
);
  // ****************************************
  // elaboration checks
  // ****************************************
  initial begin
    if (SUSPEND_CYC < 1 || SUSPEND_CYC > 255 || ABORT_CYC < 1 || ABORT_CYC > 255) begin
      $error("delay counts must be 1..255");
    end
  end

  frc_pkg::frc_state_e state_reg;
  logic [1:0] cmd_reg;
  logic [7:0] cnt_reg;
  logic [2:0] armed_reg;
  logic [2:0] pbits_reg;
  logic irq_pend_reg;
  logic is_erase;
  logic susp_allowed;
  logic rom_mode;

  assign is_erase = (cmd_reg == `FRC_CMD_ERASE);
  assign rom_mode = pbits_reg[`FRC_PB_ROM_SEL];
  assign susp_allowed = rom_mode && (is_erase ? erase_suspend_enable : program_suspend_enable);

  // ****************************************
  // command sequencer
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= frc_pkg::FRC_IDLE;
      cmd_reg <= 2'h0;
      cnt_reg <= 8'h00;
    end else if (clk_en) begin
      case (state_reg)
        frc_pkg::FRC_IDLE: begin
          if (cmd_start && pbits_reg[`FRC_PB_REWRITE_EN] &&
              (cmd_code == `FRC_CMD_ERASE || cmd_code == `FRC_CMD_PROGRAM)) begin
            state_reg <= frc_pkg::FRC_BUSY;
            cmd_reg <= cmd_code;
          end
        end
        frc_pkg::FRC_BUSY: begin
          if (fatal_irq) begin
            state_reg <= frc_pkg::FRC_ABORTING;
            cnt_reg <= 8'(ABORT_CYC);
          end else if (flash_done) begin
            state_reg <= frc_pkg::FRC_IDLE;
          end else if (maskable_irq && susp_allowed) begin
            state_reg <= frc_pkg::FRC_SUSPENDING;
            cnt_reg <= 8'(SUSPEND_CYC);
          end
        end
        frc_pkg::FRC_SUSPENDING: begin
          if (fatal_irq) begin
            state_reg <= frc_pkg::FRC_ABORTING;
            cnt_reg <= 8'(ABORT_CYC);
          end else if (cnt_reg == 8'h01) begin
            state_reg <= frc_pkg::FRC_SUSPENDED;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        frc_pkg::FRC_SUSPENDED: begin
          // resume only once software drops its request
          if (fatal_irq) begin
            state_reg <= frc_pkg::FRC_ABORTING;
            cnt_reg <= 8'(ABORT_CYC);
          end else if (!(is_erase ? erase_suspend_request : program_suspend_request)) begin
            state_reg <= frc_pkg::FRC_BUSY;
          end
        end
        frc_pkg::FRC_ABORTING: begin
          if (cnt_reg == 8'h01) begin
            state_reg <= frc_pkg::FRC_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default: state_reg <= frc_pkg::FRC_IDLE;
      endcase
    end
  end

  // ****************************************
  // interrupt acknowledge
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_ack <= 1'b0;
      irq_pend_reg <= 1'b0;
    end else if (clk_en) begin
      irq_ack <= 1'b0;
      if (state_reg == frc_pkg::FRC_BUSY && !rom_mode) begin
        irq_ack <= maskable_irq;
      end else if (state_reg == frc_pkg::FRC_BUSY && !susp_allowed) begin
        // held until the command ends; acknowledging early would fetch from busy flash
        if (maskable_irq) begin
          irq_pend_reg <= 1'b1;
        end
        if (flash_done && (irq_pend_reg || maskable_irq)) begin
          irq_ack <= 1'b1;
          irq_pend_reg <= 1'b0;
        end
      end else if (state_reg == frc_pkg::FRC_SUSPENDING && cnt_reg == 8'h01) begin
        irq_ack <= 1'b1;
      end else if (state_reg == frc_pkg::FRC_IDLE) begin
        irq_ack <= maskable_irq;
        irq_pend_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // abort, flash control and watchdog
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fatal_ack <= 1'b0;
      flash_reset <= 1'b0;
      flash_run <= 1'b0;
      wdt_tick_out <= 1'b0;
    end else if (clk_en) begin
      fatal_ack <= (state_reg == frc_pkg::FRC_ABORTING) && (cnt_reg == 8'h01);
      flash_reset <= (state_reg != frc_pkg::FRC_ABORTING && state_reg != frc_pkg::FRC_IDLE && fatal_irq) ||
                     (state_reg == frc_pkg::FRC_ABORTING && cnt_reg != 8'h01);
      flash_run <= (state_reg == frc_pkg::FRC_BUSY) && !fatal_irq && !flash_done;
      wdt_tick_out <= wdt_tick_in;
    end
  end

  // ****************************************
  // protected bits
  // ****************************************
  // a write of 0 arms the bit; any interrupt in between disarms it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pbits_reg <= 3'h0;
      armed_reg <= 3'h0;
    end else if (clk_en) begin
      if (maskable_irq || fatal_irq) begin
        armed_reg <= 3'h0;
      end
      if (pbit_wr && pbit_sel < 2'(`FRC_PB_COUNT)) begin
        if (!pbit_wdata) begin
          pbits_reg[pbit_sel] <= 1'b0;
          armed_reg[pbit_sel] <= !(maskable_irq || fatal_irq);
        end else if (armed_reg[pbit_sel] && !(maskable_irq || fatal_irq)) begin
          pbits_reg[pbit_sel] <= 1'b1;
          armed_reg[pbit_sel] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rewrite_enable_bit <= 1'b0;
      lock_disable_bit <= 1'b0;
      rom_rewrite_select_bit <= 1'b0;
      status <= '0;
    end else if (clk_en) begin
      rewrite_enable_bit <= pbits_reg[`FRC_PB_REWRITE_EN];
      lock_disable_bit <= pbits_reg[`FRC_PB_LOCK_DIS];
      rom_rewrite_select_bit <= pbits_reg[`FRC_PB_ROM_SEL];
      status.busy <= state_reg != frc_pkg::FRC_IDLE;
      status.erase_suspended <= state_reg == frc_pkg::FRC_SUSPENDED && is_erase;
      status.program_suspended <= state_reg == frc_pkg::FRC_SUSPENDED && !is_erase;
      if (state_reg == frc_pkg::FRC_ABORTING) begin
        status.aborted <= 1'b1;
      end else if (cmd_start) begin
        status.aborted <= 1'b0;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_fatal_resets: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && state_reg == frc_pkg::FRC_BUSY && fatal_irq |=> flash_reset)
    else $error("fatal irq did not reset flash");
  chk_abort_ends: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(state_reg == frc_pkg::FRC_ABORTING) |-> ##[1:300] fatal_ack)
    else $error("abort never acknowledged");
  chk_ram_ack: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && state_reg == frc_pkg::FRC_BUSY && !rom_mode && maskable_irq |=> irq_ack)
    else $error("ram mode irq not acknowledged");
  chk_hold_ack: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && state_reg == frc_pkg::FRC_BUSY && rom_mode && !susp_allowed && !flash_done |=> !irq_ack)
    else $error("irq acknowledged during held command");
  chk_susp_flag: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && state_reg == frc_pkg::FRC_SUSPENDED |=> status.erase_suspended || status.program_suspended)
    else $error("suspend not shown");
  chk_susp_enter: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(state_reg == frc_pkg::FRC_SUSPENDING) |-> ##[1:300] state_reg != frc_pkg::FRC_SUSPENDING)
    else $error("suspend delay overrun");
  chk_resume: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && state_reg == frc_pkg::FRC_SUSPENDED && !fatal_irq && !erase_suspend_request &&
    !program_suspend_request |=> state_reg == frc_pkg::FRC_BUSY)
    else $error("no resume");
  chk_pbit_seq: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && $rose(pbits_reg[0]) |-> $past(armed_reg[0]))
    else $error("protected bit set without arming");
  cov_suspend: cover property (@(posedge mclk) state_reg == frc_pkg::FRC_SUSPENDED);
  cov_abort: cover property (@(posedge mclk) fatal_ack);
  cov_held_ack: cover property (@(posedge mclk) irq_pend_reg && flash_done);
endmodule

// ### include/frc_consts.svh
`ifndef FRC_CONSTS_SVH
`define FRC_CONSTS_SVH
// ****************************************
// timing
// ****************************************
`define FRC_CLK_HZ 10000000
`define FRC_SUSPEND_DELAY_NS 1000
`define FRC_SUSPEND_DELAY_CYC ((`FRC_SUSPEND_DELAY_NS * (`FRC_CLK_HZ / 1000000) + 999) / 1000)
`define FRC_ABORT_DELAY_NS 2000
`define FRC_ABORT_DELAY_CYC ((`FRC_ABORT_DELAY_NS * (`FRC_CLK_HZ / 1000000) + 999) / 1000)
// ****************************************
// command codes
// ****************************************
`define FRC_CMD_PROGRAM 2'h1
`define FRC_CMD_ERASE 2'h2
// ****************************************
// protected bit positions
// ****************************************
`define FRC_PB_REWRITE_EN 0
`define FRC_PB_LOCK_DIS 1
`define FRC_PB_ROM_SEL 2
`define FRC_PB_COUNT 3
`endif

// ### include/frc_pkg.sv
package frc_pkg;
  typedef enum logic [2:0] {
    FRC_IDLE,
    FRC_BUSY,
    FRC_SUSPENDING,
    FRC_SUSPENDED,
    FRC_ABORTING
  } frc_state_e;

  // status shown to software
  typedef struct packed {
    logic busy;
    logic erase_suspended;
    logic program_suspended;
    logic aborted;
  } frc_status_s;
endpackage

// ### tb/frc_flash_model.sv
`timescale 1ns/1ps
// ****************************************
// flash array stand-in
// ****************************************
module frc_flash_model #(
  parameter int DONE_CYC = 30
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic flash_run,
  input wire logic flash_reset,
  output logic flash_done
);
  int cnt;
  // counts only while running, so a suspend really stalls progress
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      flash_done <= 1'h0;
    end else begin
      flash_done <= 1'h0;
      if (flash_reset) begin
        cnt <= 0;
      end else if (flash_run) begin
        cnt <= (cnt == DONE_CYC - 1) ? 0 : cnt + 1;
        flash_done <= (cnt == DONE_CYC - 1);
      end
    end
  end
endmodule

// ### tb/frc_ctrl_tb_top.sv
`timescale 1ns/1ps
// ****************************************
// bench
// ****************************************
module frc_ctrl_tb_top;
  localparam int SUS = 2;
  localparam int ABT = 4;
  localparam int DONE = 30;
  logic mclk = 1'h0, arst_n = 1'h0, cmd_start = 1'h0, es_en = 1'h0, ps_en = 1'h0;
  logic es_req = 1'h0, ps_req = 1'h0, pb_wr = 1'h0, pb_d = 1'h0, mirq = 1'h0;
  logic firq = 1'h0, tick_in = 1'h0, ce = 1'h1;
  logic [1:0] cmd_code = 2'h0, pb_sel = 2'h0;
  logic done, ack, fack, tick_out, run, frst, rew, lock, rsel;
  frc_pkg::frc_status_s st;
  wire logic [2:0] pbits = {rsel, lock, rew};
  int miscompares = 0, num_checks = 0;
  int n;
  always #50 mclk = ~mclk;
  frc_ctrl #(.SUSPEND_CYC(SUS), .ABORT_CYC(ABT)) i_frc_ctrl (.mclk(mclk), .arst_n(arst_n), .clk_en(ce),
    .cmd_start(cmd_start), .cmd_code(cmd_code), .erase_suspend_enable(es_en), .program_suspend_enable(ps_en),
    .erase_suspend_request(es_req), .program_suspend_request(ps_req), .pbit_wr(pb_wr), .pbit_sel(pb_sel),
    .pbit_wdata(pb_d), .maskable_irq(mirq), .fatal_irq(firq), .wdt_tick_in(tick_in), .flash_done(done),
    .irq_ack(ack), .fatal_ack(fack), .wdt_tick_out(tick_out), .flash_run(run), .flash_reset(frst),
    .rewrite_enable_bit(rew), .lock_disable_bit(lock), .rom_rewrite_select_bit(rsel), .status(st));
  frc_flash_model #(.DONE_CYC(DONE)) i_frc_flash_model (.mclk(mclk), .arst_n(arst_n), .flash_run(run),
    .flash_reset(frst), .flash_done(done));
  task automatic chk(logic [3:0] got, logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic pw(logic [1:0] s, logic d, logic i);
    @(posedge mclk);
    pb_wr <= 1'h1;
    pb_sel <= s;
    pb_d <= d;
    mirq <= i;
    @(posedge mclk);
    pb_wr <= 1'h0;
    mirq <= 1'h0;
    // bit outputs are registered once more behind the stored bits
    @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic start(logic [1:0] c, logic exp);
    @(posedge mclk);
    cmd_start <= 1'h1;
    cmd_code <= c;
    @(posedge mclk);
    cmd_start <= 1'h0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(run, exp);
  endtask
  // counts falling edges until the chosen acknowledge shows
  task automatic wait_ack(logic f);
    n = 0;
    while (((f ? fack : ack) !== 1'h1) && n < 100) begin
      @(negedge mclk);
      n++;
    end
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 300 && st.busy !== 1'h0; k++) @(negedge mclk);
    chk(st.busy, 1'h0);
  endtask
  task automatic t_protect();
    start(2'h2, 1'h0);
    for (int s = 0; s < 3; s++) begin
      pw(s, 1'h1, 1'h0);
      chk(pbits[s], 1'h0);
      pw(s, 1'h0, 1'h0);
      pw(s, 1'h1, 1'h1);
      chk(pbits[s], 1'h0);
      pw(s, 1'h0, 1'h0);
      @(posedge mclk) mirq <= 1'h1;
      @(posedge mclk) mirq <= 1'h0;
      pw(s, 1'h1, 1'h0);
      chk(pbits[s], 1'h0);
      pw(s, 1'h0, 1'h0);
      pw(s, 1'h1, 1'h0);
      chk(pbits[s], 1'h1);
    end
    pw(2'h2, 1'h0, 1'h0);
    chk(pbits, 3'h3);
    start(2'h3, 1'h0);
  endtask
  // a start while the clock enable is low must be lost
  task automatic t_freeze();
    @(posedge mclk) ce <= 1'h0;
    start(2'h2, 1'h0);
    chk(st.busy, 1'h0);
    @(posedge mclk) ce <= 1'h1;
  endtask
  // suspend enables must not matter in the ram-executed mode
  // cpu clock assumed divided to 10 MHz or less by software here
  // no trap instructions, address-match or non-maskable irq during commands
  task automatic t_ram_irq();
    es_en <= 1'h1;
    start(2'h2, 1'h1);
    @(posedge mclk) mirq <= 1'h1;
    wait_ack(1'h0);
    @(posedge mclk) mirq <= 1'h0;
    chk(n <= 3, 1'h1);
    chk({run, st.erase_suspended}, 2'h2);
    wait_idle();
  endtask
  task automatic t_suspend();
    // the earlier irq disarmed the select bit, so write 0 again first
    pw(2'h2, 1'h0, 1'h0);
    pw(2'h2, 1'h1, 1'h0);
    chk(rsel, 1'h1);
    ps_en <= 1'h1;
    for (int c = 2; c > 0; c--) begin
      start(c, 1'h1);
      @(posedge mclk);
      mirq <= 1'h1;
      es_req <= 1'h1;
      ps_req <= 1'h1;
      wait_ack(1'h0);
      @(posedge mclk) mirq <= 1'h0;
      chk(n >= SUS + 1 && n <= SUS + 4, 1'h1);
      repeat (2) @(negedge mclk);
      chk({st.erase_suspended, st.program_suspended}, (c == 2) ? 2'h2 : 2'h1);
      // resume before anything else; no sleep while suspended
      @(posedge mclk);
      es_req <= 1'h0;
      ps_req <= 1'h0;
      repeat (3) @(negedge mclk);
      chk({st.busy, st.erase_suspended, st.program_suspended}, 3'h4);
      wait_idle();
    end
  endtask
  task automatic t_defer();
    es_en <= 1'h0;
    ps_en <= 1'h0;
    // erase before program, never program in place twice
    for (int c = 2; c > 0; c--) begin
      start(c, 1'h1);
      @(posedge mclk) mirq <= 1'h1;
      wait_ack(1'h0);
      @(posedge mclk) mirq <= 1'h0;
      chk(n >= DONE - 4 && n <= DONE + 4, 1'h1);
      wait_idle();
    end
  endtask
  task automatic t_abort();
    start(2'h2, 1'h1);
    @(posedge mclk) tick_in <= 1'h1;
    @(posedge mclk) tick_in <= 1'h0;
    @(negedge mclk);
    chk(tick_out, 1'h1);
    @(posedge mclk) firq <= 1'h1;
    repeat (3) @(negedge mclk);
    chk({run, frst}, 2'h1);
    wait_ack(1'h1);
    @(posedge mclk) firq <= 1'h0;
    chk(n + 3 >= ABT && n + 3 <= ABT + 4, 1'h1);
    @(negedge mclk);
    chk(st.aborted, 1'h1);
    start(2'h2, 1'h1);
    chk(st.aborted, 1'h0);
    wait_idle();
  endtask
  initial begin
    repeat (7) @(posedge mclk);
    @(negedge mclk);
    chk({st.busy, ack, fack, run}, 4'h0);
    chk({frst, pbits}, 4'h0);
    @(posedge mclk) arst_n <= 1'h1;
    repeat (2) @(posedge mclk);
    t_protect();
    t_freeze();
    t_ram_irq();
    t_suspend();
    t_defer();
    t_abort();
    end_sim();
  end
  initial begin
    #2000000;
    miscompares++;
    $display("mismatch at %0t: watchdog ran out", $time);
    end_sim();
  end
endmodule
